// File: pfm_edge_det.sv
// Edge detector for the non-maskable and external interrupt inputs
`default_nettype none
module pfm_edge_det (
    input wire logic clk,
    input wire logic rst_b,
    pfm_edge_if.detector eif
);
    logic nmi_prev_r;
    logic [7:0] exi_prev_r;

    // Previous levels for edge comparison
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nmi_prev_r <= 1'h0;
            exi_prev_r <= pfm_pkg::PFM_BYTE_ZERO;
        end else begin
            nmi_prev_r <= eif.nmi_level;
            exi_prev_r <= eif.exi_level;
        end
    end

    // Either edge of the non-maskable input raises a request
    assign eif.nmi_event = eif.nmi_level ^ nmi_prev_r;

    // Per-bit enable and edge choice; both choices set means both edges
    genvar g;
    generate
        for (g = 0; g < pfm_pkg::PFM_P8_W; g++) begin : g_exi
            assign eif.exi_event[g] = eif.exi_enable[g] & (
                (eif.exi_rising[g] & eif.exi_level[g] & ~exi_prev_r[g]) |
                (eif.exi_falling[g] & ~eif.exi_level[g] & exi_prev_r[g]));
        end
    endgenerate

    nmi_both_a: assert property (@(posedge clk) disable iff (!rst_b)
        ($changed(eif.nmi_level)) |-> eif.nmi_event)
        else $error("nmi edge missed");
    exi_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!eif.exi_enable[0]) |-> !eif.exi_event[0])
        else $error("masked external interrupt fired");
endmodule
`default_nettype wire

// File: pfm_edge_if.sv
// Interface carrying the interrupt inputs and their detected events
`default_nettype none
interface pfm_edge_if;
    logic nmi_level;
    logic [7:0] exi_level;
    logic [7:0] exi_enable;
    logic [7:0] exi_rising;
    logic [7:0] exi_falling;
    logic nmi_event;
    logic [7:0] exi_event;
    modport detector (
        input nmi_level, exi_level, exi_enable, exi_rising, exi_falling,
        output nmi_event, exi_event
    );
    modport owner (
        output nmi_level, exi_level, exi_enable, exi_rising, exi_falling,
        input nmi_event, exi_event
    );
endinterface
`default_nettype wire

// File: pfm_pins.sv
// Far-side model: outside parts that set the level of every released pin on ports 4, 8 and 9
`default_nettype none
module pfm_pins (
    input wire logic [3:0] p4_out,
    input wire logic [3:0] p4_oe_b,
    input wire logic [7:0] p8_out,
    input wire logic [7:0] p8_oe_b,
    input wire logic [2:0] p9_out,
    input wire logic [2:0] p9_oe_b,
    input wire logic [3:0] ext4,
    input wire logic [7:0] ext8,
    input wire logic [2:0] ext9,
    output logic [3:0] p4_in,
    output logic [7:0] p8_in,
    output logic [2:0] p9_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // A released pin always sees a defined outside level, never a float
    assign p4_in = (p4_oe_b & ext4) | (~p4_oe_b & p4_out);
    assign p8_in = (p8_oe_b & ext8) | (~p8_oe_b & p8_out);
    assign p9_in = (p9_oe_b & ext9) | (~p9_oe_b & p9_out);
endmodule
`default_nettype wire

// File: pfm_pkg.sv
// Package of selection codes, port widths and reset values for the pin multiplexer
`default_nettype none
package pfm_pkg;
    // Pin function selection codes
    typedef enum logic [1:0] {
        PFM_SEL_PRI = 2'h0,
        PFM_SEL_SEC = 2'h1,
        PFM_SEL_TER = 2'h2
    } pfm_sel_t;
    localparam int PFM_P2_W = 3;
    localparam int PFM_P4_W = 4;
    localparam int PFM_P8_W = 8;
    localparam int PFM_P9_W = 3;
    localparam logic [1:0] PFM_SEL_RST = 2'h0;
    localparam logic [7:0] PFM_BYTE_ZERO = 8'h00;
    // Bit positions of the serial channel pins within ports 4 and 8, and of the clock outputs on port 2
    localparam int PFM_SIN_BIT = 0;
    localparam int PFM_SCK_BIT = 1;
    localparam int PFM_SOUT_BIT = 2;
    localparam int PFM_S1_SIN8 = 4;
    localparam int PFM_S1_SCK8 = 5;
    localparam int PFM_S1_SOUT8 = 6;
    localparam int PFM_SDA_BIT = 0;
    localparam int PFM_SCL_BIT = 1;
    localparam int PFM_RXD_BIT = 6;
    localparam int PFM_TXD_BIT = 7;
    localparam int PFM_LOW_SPEED_CLOCK_OUT_BIT = 0;
    localparam int PFM_HSCLK_BIT = 1;
endpackage
`default_nettype wire

// File: pfm_top.sv
// Port function multiplexer: routes port pins to port bits or peripheral signals
`default_nettype none
module pfm_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] p2_sel,
    input wire logic [7:0] p4_sel,
    input wire logic [15:0] p8_sel,
    input wire logic sel_load,
    input wire logic [2:0] p2_data,
    input wire logic [2:0] p2_led_en,
    input wire logic [3:0] p4_data,
    input wire logic [3:0] p4_dir,
    input wire logic [7:0] p8_data,
    input wire logic [7:0] p8_dir,
    input wire logic [2:0] p9_data,
    input wire logic [2:0] p9_dir,
    input wire logic low_speed_clock,
    input wire logic high_speed_clock,
    input wire logic serial0_dout,
    input wire logic serial0_sck_out,
    input wire logic serial0_sck_oe,
    input wire logic serial0_on_p8,
    input wire logic serial1_dout,
    input wire logic serial1_sck_out,
    input wire logic serial1_sck_oe,
    input wire logic i2c_sda_low,
    input wire logic i2c_scl_low,
    input wire logic uart_tx,
    input wire logic [7:0] exi_enable,
    input wire logic [7:0] exi_rising,
    input wire logic [7:0] exi_falling,
    input wire logic nmi_pin,
    input wire logic [3:0] p4_in,
    input wire logic [7:0] p8_in,
    input wire logic [2:0] p9_in,
    output logic [2:0] p2_out,
    output logic [2:0] p2_oe_b,
    output logic [3:0] p4_out,
    output logic [3:0] p4_oe_b,
    output logic [7:0] p8_out,
    output logic [7:0] p8_oe_b,
    output logic [2:0] p9_out,
    output logic [2:0] p9_oe_b,
    output logic [3:0] port4_read,
    output logic [7:0] port8_read,
    output logic [2:0] port9_read,
    output logic [3:0] analog_sel_in,
    output logic serial0_din,
    output logic serial0_sck_in,
    output logic serial1_din,
    output logic serial1_sck_in,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    output logic uart_rx,
    output logic nmi_req,
    output logic [7:0] exi_req
);
    logic [5:0] p2_sel_r;
    logic [7:0] p4_sel_r;
    logic [15:0] p8_sel_r;
    logic [3:0] p4_pri;
    logic [7:0] p8_pri;
    logic [2:0] p2_nxt;
    logic [2:0] p2_oe_nxt;
    logic [3:0] p4_nxt;
    logic [3:0] p4_oe_nxt;
    logic [7:0] p8_nxt;
    logic [7:0] p8_oe_nxt;

    // Two-bit selection code of one pin
    function automatic logic [1:0] sel_of(input logic [15:0] v, input int i);
        sel_of = v[2 * i +: 2];
    endfunction

    // Selection fields; pins start in their primary function
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p2_sel_r <= {3{pfm_pkg::PFM_SEL_RST}};
            p4_sel_r <= {4{pfm_pkg::PFM_SEL_RST}};
            p8_sel_r <= {8{pfm_pkg::PFM_SEL_RST}};
        end else if (sel_load) begin
            p2_sel_r <= p2_sel;
            p4_sel_r <= p4_sel;
            p8_sel_r <= p8_sel;
        end
    end

    // Primary flags gate port data; any other code removes the port bit
    genvar g;
    generate
        for (g = 0; g < pfm_pkg::PFM_P4_W; g++) begin : g_p4
            assign p4_pri[g] = sel_of({8'h00, p4_sel_r}, g) == pfm_pkg::PFM_SEL_PRI;
        end
        for (g = 0; g < pfm_pkg::PFM_P8_W; g++) begin : g_p8
            assign p8_pri[g] = sel_of(p8_sel_r, g) == pfm_pkg::PFM_SEL_PRI;
        end
    endgenerate

    // Output port 2: port or LED drive, except bits 0 and 1 carry clocks when secondary
    always_comb begin
        p2_nxt = p2_data;
        p2_oe_nxt = 3'h0;
        for (int i = 0; i < pfm_pkg::PFM_P2_W; i++) begin
            if (p2_led_en[i]) begin
                // LED sink mode: open drain, released when data is high
                p2_oe_nxt[i] = p2_data[i];
                p2_nxt[i] = 1'h0;
            end
        end
        if (sel_of({10'h000, p2_sel_r}, pfm_pkg::PFM_LOW_SPEED_CLOCK_OUT_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p2_nxt[pfm_pkg::PFM_LOW_SPEED_CLOCK_OUT_BIT] = low_speed_clock;
            p2_oe_nxt[pfm_pkg::PFM_LOW_SPEED_CLOCK_OUT_BIT] = 1'h0;
        end
        if (sel_of({10'h000, p2_sel_r}, pfm_pkg::PFM_HSCLK_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p2_nxt[pfm_pkg::PFM_HSCLK_BIT] = high_speed_clock;
            p2_oe_nxt[pfm_pkg::PFM_HSCLK_BIT] = 1'h0;
        end
    end

    // Port 4: primary is port bit, secondary is serial 1, tertiary is serial 0
    always_comb begin
        p4_nxt = p4_data;
        p4_oe_nxt = ~p4_dir;
        for (int i = 0; i < pfm_pkg::PFM_P4_W; i++) begin
            if (!p4_pri[i]) begin
                p4_nxt[i] = 1'h0;
                p4_oe_nxt[i] = 1'h1;
            end
        end
        if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SCK_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p4_nxt[pfm_pkg::PFM_SCK_BIT] = serial1_sck_out;
            p4_oe_nxt[pfm_pkg::PFM_SCK_BIT] = ~serial1_sck_oe;
        end else if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SCK_BIT) == pfm_pkg::PFM_SEL_TER
                     && !serial0_on_p8) begin
            p4_nxt[pfm_pkg::PFM_SCK_BIT] = serial0_sck_out;
            p4_oe_nxt[pfm_pkg::PFM_SCK_BIT] = ~serial0_sck_oe;
        end
        if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SOUT_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p4_nxt[pfm_pkg::PFM_SOUT_BIT] = serial1_dout;
            p4_oe_nxt[pfm_pkg::PFM_SOUT_BIT] = 1'h0;
        end else if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SOUT_BIT) == pfm_pkg::PFM_SEL_TER
                     && !serial0_on_p8) begin
            p4_nxt[pfm_pkg::PFM_SOUT_BIT] = serial0_dout;
            p4_oe_nxt[pfm_pkg::PFM_SOUT_BIT] = 1'h0;
        end
    end

    // Port 8: I2C and UART secondary, serial channels tertiary
    always_comb begin
        p8_nxt = p8_data;
        p8_oe_nxt = ~p8_dir;
        for (int i = 0; i < pfm_pkg::PFM_P8_W; i++) begin
            if (!p8_pri[i]) begin
                p8_nxt[i] = 1'h0;
                p8_oe_nxt[i] = 1'h1;
            end
        end
        if (sel_of(p8_sel_r, pfm_pkg::PFM_SDA_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p8_oe_nxt[pfm_pkg::PFM_SDA_BIT] = ~i2c_sda_low;
        end
        if (sel_of(p8_sel_r, pfm_pkg::PFM_SCL_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p8_oe_nxt[pfm_pkg::PFM_SCL_BIT] = ~i2c_scl_low;
        end else if (sel_of(p8_sel_r, pfm_pkg::PFM_SCL_BIT) == pfm_pkg::PFM_SEL_TER
                     && serial0_on_p8) begin
            p8_nxt[pfm_pkg::PFM_SCL_BIT] = serial0_sck_out;
            p8_oe_nxt[pfm_pkg::PFM_SCL_BIT] = ~serial0_sck_oe;
        end
        if (sel_of(p8_sel_r, pfm_pkg::PFM_SOUT_BIT) == pfm_pkg::PFM_SEL_TER && serial0_on_p8) begin
            p8_nxt[pfm_pkg::PFM_SOUT_BIT] = serial0_dout;
            p8_oe_nxt[pfm_pkg::PFM_SOUT_BIT] = 1'h0;
        end
        if (sel_of(p8_sel_r, pfm_pkg::PFM_S1_SCK8) == pfm_pkg::PFM_SEL_TER) begin
            p8_nxt[pfm_pkg::PFM_S1_SCK8] = serial1_sck_out;
            p8_oe_nxt[pfm_pkg::PFM_S1_SCK8] = ~serial1_sck_oe;
        end
        if (sel_of(p8_sel_r, pfm_pkg::PFM_S1_SOUT8) == pfm_pkg::PFM_SEL_TER) begin
            p8_nxt[pfm_pkg::PFM_S1_SOUT8] = serial1_dout;
            p8_oe_nxt[pfm_pkg::PFM_S1_SOUT8] = 1'h0;
        end
        if (sel_of(p8_sel_r, pfm_pkg::PFM_TXD_BIT) == pfm_pkg::PFM_SEL_SEC) begin
            p8_nxt[pfm_pkg::PFM_TXD_BIT] = uart_tx;
            p8_oe_nxt[pfm_pkg::PFM_TXD_BIT] = 1'h0;
        end
    end

    // Pin drivers are registered; reset releases every pin so nothing is driven
    // before software sets the ports up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            p2_out <= 3'h0;
            p2_oe_b <= 3'h7;
            p4_out <= 4'h0;
            p4_oe_b <= 4'hF;
            p8_out <= pfm_pkg::PFM_BYTE_ZERO;
            p8_oe_b <= 8'hFF;
            p9_out <= 3'h0;
            p9_oe_b <= 3'h7;
        end else begin
            p2_out <= p2_nxt;
            p2_oe_b <= p2_oe_nxt;
            p4_out <= p4_nxt;
            p4_oe_b <= p4_oe_nxt;
            p8_out <= p8_nxt;
            p8_oe_b <= p8_oe_nxt;
            p9_out <= p9_data;
            p9_oe_b <= ~p9_dir;
        end
    end

    // Pin levels stay readable whatever the selection
    assign port4_read = p4_in;
    assign port8_read = p8_in;
    assign port9_read = p9_in;
    // Analog channels only see their pin while it is primary
    assign analog_sel_in = p4_in & p4_pri;

    // Peripheral inputs see the pin only when routed there, else idle high
    always_comb begin
        serial0_din = 1'h1;
        serial0_sck_in = 1'h1;
        if (serial0_on_p8) begin
            if (sel_of(p8_sel_r, pfm_pkg::PFM_SIN_BIT) == pfm_pkg::PFM_SEL_TER)
                serial0_din = p8_in[pfm_pkg::PFM_SIN_BIT];
            if (sel_of(p8_sel_r, pfm_pkg::PFM_SCK_BIT) == pfm_pkg::PFM_SEL_TER)
                serial0_sck_in = p8_in[pfm_pkg::PFM_SCK_BIT];
        end else begin
            if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SIN_BIT) == pfm_pkg::PFM_SEL_TER)
                serial0_din = p4_in[pfm_pkg::PFM_SIN_BIT];
            if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SCK_BIT) == pfm_pkg::PFM_SEL_TER)
                serial0_sck_in = p4_in[pfm_pkg::PFM_SCK_BIT];
        end
    end

    always_comb begin
        serial1_din = 1'h1;
        serial1_sck_in = 1'h1;
        if (sel_of(p8_sel_r, pfm_pkg::PFM_S1_SIN8) == pfm_pkg::PFM_SEL_TER)
            serial1_din = p8_in[pfm_pkg::PFM_S1_SIN8];
        else if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SIN_BIT) == pfm_pkg::PFM_SEL_SEC)
            serial1_din = p4_in[pfm_pkg::PFM_SIN_BIT];
        if (sel_of(p8_sel_r, pfm_pkg::PFM_S1_SCK8) == pfm_pkg::PFM_SEL_TER)
            serial1_sck_in = p8_in[pfm_pkg::PFM_S1_SCK8];
        else if (sel_of({8'h00, p4_sel_r}, pfm_pkg::PFM_SCK_BIT) == pfm_pkg::PFM_SEL_SEC)
            serial1_sck_in = p4_in[pfm_pkg::PFM_SCK_BIT];
    end

    assign i2c_sda_in = (sel_of(p8_sel_r, pfm_pkg::PFM_SDA_BIT) == pfm_pkg::PFM_SEL_SEC)
                        ? p8_in[pfm_pkg::PFM_SDA_BIT] : 1'h1;
    assign i2c_scl_in = (sel_of(p8_sel_r, pfm_pkg::PFM_SCL_BIT) == pfm_pkg::PFM_SEL_SEC)
                        ? p8_in[pfm_pkg::PFM_SCL_BIT] : 1'h1;
    assign uart_rx = (sel_of(p8_sel_r, pfm_pkg::PFM_RXD_BIT) == pfm_pkg::PFM_SEL_SEC)
                     ? p8_in[pfm_pkg::PFM_RXD_BIT] : 1'h1;

    // Interrupt edge detection on port 8; a pin given to another function
    // loses its interrupt, gated at the enable so no false edge appears
    pfm_edge_if eif ();
    assign eif.nmi_level = nmi_pin;
    assign eif.exi_level = p8_in;
    assign eif.exi_enable = exi_enable & p8_pri;
    assign eif.exi_rising = exi_rising;
    assign eif.exi_falling = exi_falling;
    pfm_edge_det u_edge (
        .clk(clk),
        .rst_b(rst_b),
        .eif(eif)
    );
    assign nmi_req = eif.nmi_event;
    assign exi_req = eif.exi_event;

    sequence sda_pull_s;
        sel_of(p8_sel_r, pfm_pkg::PFM_SDA_BIT) == pfm_pkg::PFM_SEL_SEC && i2c_sda_low;
    endsequence
    i2c_sda_a: assert property (@(posedge clk) disable iff (!rst_b)
        sda_pull_s |=> (!p8_oe_b[0] && !p8_out[0]))
        else $error("sda not pulled low");
    i2c_od_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sel_of(p8_sel_r, pfm_pkg::PFM_SDA_BIT) == pfm_pkg::PFM_SEL_SEC) |=> !p8_out[0])
        else $error("sda driven high");
    txd_route_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sel_of(p8_sel_r, pfm_pkg::PFM_TXD_BIT) == pfm_pkg::PFM_SEL_SEC)
        |=> (p8_out[7] == $past(uart_tx) && !p8_oe_b[7]))
        else $error("uart tx not routed");
    low_speed_clock_out_route_a: assert property (@(posedge clk) disable iff (!rst_b)
        (p2_sel_r[1:0] == pfm_pkg::PFM_SEL_SEC) |=> (p2_out[0] == $past(low_speed_clock)))
        else $error("low clock not routed");
    hsclk_route_a: assert property (@(posedge clk) disable iff (!rst_b)
        (p2_sel_r[3:2] == pfm_pkg::PFM_SEL_SEC) |=> (p2_out[1] == $past(high_speed_clock)))
        else $error("high clock not routed");
    port_cut_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!p8_pri[3]) |=> p8_oe_b[3])
        else $error("deselected port bit still driven");
    exi_cut_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!p8_pri[pfm_pkg::PFM_SDA_BIT]) |-> !exi_req[pfm_pkg::PFM_SDA_BIT])
        else $error("deselected pin raised interrupt");
    read_back_a: assert property (@(posedge clk) disable iff (!rst_b)
        port8_read == p8_in)
        else $error("port read lost pin level");
    analog_cut_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!p4_pri[0]) |-> !analog_sel_in[0])
        else $error("analog input not isolated");
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the port function multiplexer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, sel_load, low_speed_clock, high_speed_clock, serial0_dout, serial0_sck_out;
    logic serial0_sck_oe, serial0_on_p8, serial1_dout, serial1_sck_out, serial1_sck_oe, uart_tx;
    logic i2c_sda_low, i2c_scl_low, nmi_pin, serial0_din, serial0_sck_in, serial1_din;
    logic serial1_sck_in, i2c_sda_in, i2c_scl_in, uart_rx, nmi_req, prev_nmi;
    logic [5:0] p2_sel;
    logic [15:0] p8_sel;
    logic [2:0] p2_data, p2_led_en, p9_data, p9_dir, ext9, p2_out, p2_oe_b, p9_out, p9_oe_b;
    logic [2:0] port9_read, p9_in, l9;
    logic [3:0] p4_data, p4_dir, ext4, p4_out, p4_oe_b, port4_read, analog_sel_in, p4_in, l4;
    logic [7:0] p8_data, p8_dir, ext8, exi_enable, exi_rising, exi_falling, p8_out, p8_oe_b;
    logic [7:0] port8_read, exi_req, p8_in, l8, prev8, prim, ev;
    logic [1:0] es2 [3];
    logic [1:0] es4 [4];
    logic [1:0] es8 [8];
    logic [1:0] pe2 [3];
    logic [1:0] pe4 [4];
    logic [1:0] pe8 [8];
    logic [1:0] pe9 [3];
    logic [7:0] p4_sel_w;
    int err_total, n_compared;
    // Legal select codes per pin, one mask bit per code
    localparam logic [3:0] M2 [3] = '{4'hB, 4'hB, 4'h9};
    localparam logic [3:0] M4 [4] = '{4'hF, 4'hF, 4'hF, 4'h9};
    localparam logic [3:0] M8 [8] = '{4'hF, 4'hF, 4'hD, 4'h9, 4'hD, 4'hD, 4'hF, 4'hB};

    assign p4_sel_w = {es4[3], es4[2], es4[1], es4[0]};
    pfm_top dut (.clk, .rst_b, .p2_sel, .p4_sel(p4_sel_w), .p8_sel, .sel_load, .p2_data,
        .p2_led_en, .p4_data, .p4_dir, .p8_data, .p8_dir, .p9_data, .p9_dir, .low_speed_clock,
        .high_speed_clock, .serial0_dout, .serial0_sck_out, .serial0_sck_oe, .serial0_on_p8,
        .serial1_dout, .serial1_sck_out, .serial1_sck_oe, .i2c_sda_low, .i2c_scl_low, .uart_tx,
        .exi_enable, .exi_rising, .exi_falling, .nmi_pin, .p4_in, .p8_in, .p9_in, .p2_out,
        .p2_oe_b, .p4_out, .p4_oe_b, .p8_out, .p8_oe_b, .p9_out, .p9_oe_b, .port4_read,
        .port8_read, .port9_read, .analog_sel_in, .serial0_din, .serial0_sck_in, .serial1_din,
        .serial1_sck_in, .i2c_sda_in, .i2c_scl_in, .uart_rx, .nmi_req, .exi_req);
    pfm_pins pins (.p4_out, .p4_oe_b, .p8_out, .p8_oe_b, .p9_out, .p9_oe_b, .ext4, .ext8,
        .ext9, .p4_in, .p8_in, .p9_in);

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Expected pin drive {oe_b, out} for one pin under one select code
    function automatic logic [1:0] drv(int pt, int b, logic [1:0] s);
        // Output port 2 keeps its port drive for any code but secondary
        if (s == 2'h3 && pt != 2) return 2'h2;
        if (s == 2'h0 || (pt == 2 && s != 2'h1)) begin
            if (pt == 2) return p2_led_en[b] ? {p2_data[b], 1'b0} : {1'b0, p2_data[b]};
            if (pt == 4) return {~p4_dir[b], p4_data[b]};
            if (pt == 8) return {~p8_dir[b], p8_data[b]};
            return {~p9_dir[b], p9_data[b]};
        end
        if (pt == 2) return {1'b0, b == 0 ? low_speed_clock : high_speed_clock};
        if (pt == 8 && s == 2'h1) begin
            if (b == 7) return {1'b0, uart_tx};
            if (b == 6) return 2'h2;
            return {~(b == 0 ? i2c_sda_low : i2c_scl_low), 1'b0};
        end
        if ((pt == 4 && s == 2'h1) || (pt == 8 && b > 3))
            return b % 4 == 0 ? 2'h2 : b % 4 == 1 ? {~serial1_sck_oe, serial1_sck_out}
                : {1'b0, serial1_dout};
        return b == 0 ? 2'h2 : b == 1 ? {~serial0_sck_oe, serial0_sck_out} : {1'b0, serial0_dout};
    endfunction

    // Routed input level, idle high when the pin is not given to that function
    function automatic logic rt(logic [1:0] s, logic [1:0] want, logic lv);
        return s == want ? lv : 1'b1;
    endfunction

    function automatic logic [1:0] pick(logic [3:0] m);
        logic [1:0] c;
        c = 2'($urandom % 4);
        while (!m[c]) c = 2'($urandom % 4);
        return c;
    endfunction

    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cmp(string nm, logic oe, logic o, logic [1:0] e);
        check(nm, 8'(oe), 8'(e[1]));
        if (e[1] == 1'b0) check(nm, 8'(o), 8'(e[0]));
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One cycle: check registered drive, apply new inputs, check live routing
    task automatic step(bit chk);
        @(negedge clk);
        if (chk) begin
            for (int i = 0; i < 3; i++) cmp("p2 pin", p2_oe_b[i], p2_out[i], pe2[i]);
            for (int i = 0; i < 4; i++) cmp("p4 pin", p4_oe_b[i], p4_out[i], pe4[i]);
            for (int i = 0; i < 8; i++) cmp("p8 pin", p8_oe_b[i], p8_out[i], pe8[i]);
            for (int i = 0; i < 3; i++) cmp("p9 pin", p9_oe_b[i], p9_out[i], pe9[i]);
        end
        {p2_data, p2_led_en, p4_data, p4_dir, ext4, p9_data, p9_dir, ext9} = 27'($urandom);
        {p8_data, p8_dir, ext8, exi_enable} = $urandom;
        {exi_rising, exi_falling, low_speed_clock, high_speed_clock, serial0_dout, serial0_sck_out,
            serial0_sck_oe, serial1_dout, serial1_sck_out, serial1_sck_oe, i2c_sda_low,
            i2c_scl_low, uart_tx, nmi_pin} = 28'($urandom);
        for (int i = 0; i < 4; i++) l4[i] = pe4[i][1] ? ext4[i] : pe4[i][0];
        for (int i = 0; i < 8; i++) l8[i] = pe8[i][1] ? ext8[i] : pe8[i][0];
        for (int i = 0; i < 3; i++) l9[i] = pe9[i][1] ? ext9[i] : pe9[i][0];
        for (int i = 0; i < 8; i++) prim[i] = es8[i] == 2'h0;
        ev = exi_enable & ((l8 & ~prev8 & exi_rising) | (~l8 & prev8 & exi_falling));
        #1;
        if (chk) begin
            check("port reads", {port9_read, port4_read}, {l9, l4});
            check("port8 read", port8_read, l8);
            check("analog", analog_sel_in, {es4[3] == 2'h0, es4[2] == 2'h0, es4[1] == 2'h0,
                es4[0] == 2'h0} & l4);
            check("nmi", nmi_req, nmi_pin ^ prev_nmi);
            check("exi", exi_req, ev & prim);
            check("serial in", {serial0_din, serial0_sck_in, serial1_din, serial1_sck_in},
                {serial0_on_p8 ? rt(es8[0], 2'h2, l8[0]) : rt(es4[0], 2'h2, l4[0]),
                serial0_on_p8 ? rt(es8[1], 2'h2, l8[1]) : rt(es4[1], 2'h2, l4[1]),
                es8[4] == 2'h2 ? l8[4] : rt(es4[0], 2'h1, l4[0]),
                es8[5] == 2'h2 ? l8[5] : rt(es4[1], 2'h1, l4[1])});
            check("i2c uart in", {i2c_sda_in, i2c_scl_in, uart_rx}, {rt(es8[0], 2'h1, l8[0]),
                rt(es8[1], 2'h1, l8[1]), rt(es8[6], 2'h1, l8[6])});
        end
        prev_nmi = nmi_pin;
        prev8 = l8;
        for (int i = 0; i < 3; i++) pe2[i] = drv(2, i, es2[i]);
        for (int i = 0; i < 4; i++) pe4[i] = drv(4, i, es4[i]);
        for (int i = 0; i < 8; i++) pe8[i] = drv(8, i, es8[i]);
        for (int i = 0; i < 3; i++) pe9[i] = drv(9, i, 2'h0);
    endtask

    // Capture a new set of selects; serial0 port chosen first to avoid clashes
    task automatic load(bit all_off);
        @(negedge clk);
        serial0_on_p8 = 1'($urandom);
        for (int i = 0; i < 8; i++) begin
            es8[i] = all_off ? 2'h3 : pick(M8[i] & ((i < 3 && !serial0_on_p8) ? 4'hB : 4'hF));
            p8_sel[2 * i +: 2] = es8[i];
        end
        for (int i = 0; i < 4; i++)
            es4[i] = all_off ? 2'h3 : pick(M4[i] & ((i < 3 && serial0_on_p8) ? 4'hB : 4'hF));
        for (int i = 0; i < 3; i++) begin
            es2[i] = all_off ? 2'h3 : pick(M2[i]);
            p2_sel[2 * i +: 2] = es2[i];
        end
        sel_load = 1'b1;
        @(negedge clk);
        sel_load = 1'b0;
        repeat (3) step(0);
    endtask

    task automatic to_primary;
        for (int i = 0; i < 8; i++) es8[i] = 2'h0;
        for (int i = 0; i < 4; i++) es4[i] = 2'h0;
        for (int i = 0; i < 3; i++) es2[i] = 2'h0;
    endtask

    // Main sequence
    initial begin
        err_total = 0;
        n_compared = 0;
        void'($urandom(81487));
        rst_b = 1'b0;
        sel_load = 1'b0;
        p2_sel = 6'h3F;
        p8_sel = 16'hFFFF;
        serial0_on_p8 = 1'b0;
        prev_nmi = 1'b0;
        prev8 = 8'h00;
        to_primary();
        {p2_data, p2_led_en, p4_data, p4_dir, ext4, p9_data, p9_dir, ext9} = 27'h0000000;
        {p8_data, p8_dir, ext8, exi_enable} = 32'h00000000;
        {exi_rising, exi_falling, low_speed_clock, high_speed_clock, serial0_dout, serial0_sck_out,
            serial0_sck_oe, serial1_dout, serial1_sck_out, serial1_sck_oe, i2c_sda_low,
            i2c_scl_low, uart_tx, nmi_pin} = 28'h0000000;
        repeat (5) @(negedge clk);
        check("reset release", {p2_oe_b, p4_oe_b}, 8'h7F);
        check("reset release", {p9_oe_b, 5'h00} | 8'h1F, 8'hFF);
        check("reset release", p8_oe_b, 8'hFF);
        rst_b = 1'b1;
        // Port 2 and port 8 select inputs hold all-ones but are never loaded: pins stay primary
        repeat (2) step(0);
        repeat (20) step(1);
        $display("test primary done");
        load(1);
        repeat (10) step(1);
        $display("test released done");
        repeat (30) begin
            load(0);
            repeat (15) step(1);
        end
        $display("test random done");
        // Reset in mid-run drops every select back to primary
        @(negedge clk);
        rst_b = 1'b0;
        #1;
        check("mid reset", {p2_oe_b, p4_oe_b}, 8'h7F);
        check("mid reset", p8_oe_b, 8'hFF);
        @(negedge clk);
        rst_b = 1'b1;
        to_primary();
        prev_nmi = 1'b0;
        repeat (2) step(0);
        repeat (10) step(1);
        $display("test reset done");
        test_done();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(4000 * 50);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
